// *** rtl/hdu_uart.sv ***
// Half-duplex nine-bit asynchronous transceiver with an Avalon-MM register slave.
//
// Overview of operation
// - Idle receiver waits falling edge, skips start bit.
// - Received ninth bit overwrites ninth-bit field.
// - After nine bits, stop bit, then buffer load.
// - Buffer load sets receive-full flag, interrupt if enabled.
// - Transmit start abandons any reception in progress.
// - Each interrupt gated by its own enable bit.
// - Data write loads shifter, starts, clears empty flag.
// - Data read returns receive buffer.
// - Rate code selects internal clock divisor.
// - Rate change takes effect immediately.
// - Receive-full bit 7: write 0 clears, 1 sets.
// - Empty bit 6 set on completion, write 0 clears, 1 sets.
// - Receive enable bit 5 gates receive interrupt.
// - Transmit enable bit 4 gates transmit interrupt.
// - Bit 0 written for transmit, reads received bit.
// - Each bit decided by two-of-three majority.
// - Frame: start 0, eight LSB first, ninth, stop 1.
// - Serial output pin is inverted.
// - Idle output pin follows port register level.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module hdu_uart (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic [hdu_pkg::HDU_ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_rxd,
   input wire logic i_port_level,
   output logic o_txd,
   output logic o_transmit_output_select,
   output logic o_rx_irq,
   output logic o_tx_irq
);
   import hdu_pkg::*;

   hdu_state_t state_ff;
   hdu_state_t nxt_state;
   logic rx_s1_ff;
   logic rx_s2_ff;
   logic rx_prev_ff;
   logic receive_full_flag_ff;
   logic transmit_empty_flag_ff;
   logic receive_irq_enable_ff;
   logic transmit_irq_enable_ff;
   logic [2:0] rate_select_ff;
   logic ninth_bit_ff;
   logic [7:0] rx_buf_ff;
   logic [8:0] rx_shift_ff;
   logic [10:0] tx_shift_ff;
   logic [2:0] phase_ff;
   logic [3:0] bit_cnt_ff;
   logic [2:0] samp_ff;
   logic tick;
   logic bit_end;
   logic fall;
   logic majority;
   logic bus_req;
   logic bus_taken;
   logic hit_data;
   logic hit_ctrl;
   logic wr_data;
   logic wr_ctrl;
   logic tx_start;
   logic rx_done;
   logic tx_done;
   logic restart;
   logic [7:0] ctrl_image;
   logic [7:0] wbyte;

   // The pin is asynchronous: two flops, and only the second and later feed logic.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rx_s1_ff <= 1'b1;
         rx_s2_ff <= 1'b1;
         rx_prev_ff <= 1'b1;
      end else begin
         rx_s1_ff <= i_rxd;
         rx_s2_ff <= rx_s1_ff;
         rx_prev_ff <= rx_s2_ff;
      end
   end

   // Bus decode; a request is answered one cycle after it appears.
   assign bus_req = i_avs_read | i_avs_write;
   assign bus_taken = bus_req & ~o_avs_waitrequest;
   assign hit_data = (i_avs_address == HDU_ADDR_DATA);
   assign hit_ctrl = (i_avs_address == HDU_ADDR_CTRL);
   assign wbyte = i_avs_writedata[7:0];
   assign wr_data = bus_taken & i_avs_write & hit_data & i_avs_byteenable[0];
   assign wr_ctrl = bus_taken & i_avs_write & hit_ctrl & i_avs_byteenable[0];
   assign ctrl_image = {receive_full_flag_ff, transmit_empty_flag_ff, receive_irq_enable_ff,
      transmit_irq_enable_ff, rate_select_ff, ninth_bit_ff};

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_avs_waitrequest <= HDU_WAIT_RST;
      end else if (bus_taken) begin
         o_avs_waitrequest <= 1'b1;
      end else if (bus_req) begin
         o_avs_waitrequest <= 1'b0;
      end
   end

   // Read data is captured while the request still waits; unmapped reads return zero.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_avs_readdata <= HDU_RDATA_RST;
      end else if (i_avs_read && o_avs_waitrequest) begin
         if (hit_data) begin
            o_avs_readdata <= {24'h000000, rx_buf_ff};
         end else if (hit_ctrl) begin
            o_avs_readdata <= {24'h000000, ctrl_image};
         end else begin
            o_avs_readdata <= HDU_RDATA_RST;
         end
      end
   end

   // Transmit and receive share one divider, phase counter and bit counter.
   assign tx_start = wr_data;
   assign fall = rx_prev_ff & ~rx_s2_ff;
   assign restart = tx_start | ((state_ff == HDU_ST_IDLE) & fall);
   assign bit_end = tick & (phase_ff == HDU_LAST_PHASE);

   hdu_rate_tick u_rate_tick (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_restart(restart),
      .i_limit(hdu_tick_limit(rate_select_ff)),
      .o_tick(tick)
   );

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         HDU_ST_IDLE: begin
            if (tx_start) begin
               nxt_state = HDU_ST_TX;
            end else if (fall) begin
               nxt_state = HDU_ST_RX_START;
            end
         end
         HDU_ST_RX_START: begin
            if (tx_start) begin
               nxt_state = HDU_ST_TX;
            end else if (bit_end) begin
               nxt_state = HDU_ST_RX_DATA;
            end
         end
         HDU_ST_RX_DATA: begin
            if (tx_start) begin
               nxt_state = HDU_ST_TX;
            end else if (bit_end && bit_cnt_ff == HDU_LAST_RX_BIT) begin
               nxt_state = HDU_ST_RX_STOP;
            end
         end
         HDU_ST_RX_STOP: begin
            if (tx_start) begin
               nxt_state = HDU_ST_TX;
            end else if (bit_end) begin
               nxt_state = HDU_ST_IDLE;
            end
         end
         HDU_ST_TX: begin
            if (!tx_start && bit_end && bit_cnt_ff == HDU_LAST_TX_BIT) begin
               nxt_state = HDU_ST_IDLE;
            end
         end
         default: begin
            nxt_state = HDU_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         state_ff <= HDU_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign rx_done = (state_ff == HDU_ST_RX_STOP) & bit_end & ~tx_start;
   assign tx_done = (state_ff == HDU_ST_TX) & bit_end & (bit_cnt_ff == HDU_LAST_TX_BIT) & ~tx_start;

   always_ff @(posedge i_mclk) begin
      if (i_srst || restart) begin
         phase_ff <= 3'h0;
         bit_cnt_ff <= 4'h0;
      end else if (tick) begin
         phase_ff <= phase_ff + 3'h1;
         if (bit_end && (state_ff == HDU_ST_RX_DATA || state_ff == HDU_ST_TX)) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
         end
      end
   end

   // Three samples mid-bit; the outer phases absorb rate mismatch with the sender.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         samp_ff <= 3'h7;
      end else if (tick) begin
         if (phase_ff == HDU_SAMPLE_A) begin
            samp_ff[0] <= rx_s2_ff;
         end
         if (phase_ff == HDU_SAMPLE_B) begin
            samp_ff[1] <= rx_s2_ff;
         end
         if (phase_ff == HDU_SAMPLE_C) begin
            samp_ff[2] <= rx_s2_ff;
         end
      end
   end

   assign majority = (samp_ff[0] & samp_ff[1]) | (samp_ff[0] & samp_ff[2]) | (samp_ff[1] & samp_ff[2]);

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rx_shift_ff <= 9'h000;
      end else if (bit_end && state_ff == HDU_ST_RX_DATA && !tx_start) begin
         rx_shift_ff <= {majority, rx_shift_ff[8:1]};
      end
   end

   // The buffer is separate from the shifter so the next character can arrive while it is read.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rx_buf_ff <= 8'h00;
      end else if (rx_done) begin
         rx_buf_ff <= rx_shift_ff[7:0];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         tx_shift_ff <= 11'h7ff;
      end else if (tx_start) begin
         tx_shift_ff <= {1'b1, ninth_bit_ff, wbyte, 1'b0};
      end else if (bit_end && state_ff == HDU_ST_TX) begin
         tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
      end
   end

   // Hardware events win over a software write in the same cycle.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         receive_full_flag_ff <= 1'b0;
      end else if (rx_done) begin
         receive_full_flag_ff <= 1'b1;
      end else if (wr_ctrl) begin
         receive_full_flag_ff <= wbyte[HDU_BIT_RXF];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         transmit_empty_flag_ff <= 1'b0;
      end else if (tx_done) begin
         transmit_empty_flag_ff <= 1'b1;
      end else if (tx_start) begin
         transmit_empty_flag_ff <= 1'b0;
      end else if (wr_ctrl) begin
         transmit_empty_flag_ff <= wbyte[HDU_BIT_TXE];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         receive_irq_enable_ff <= 1'b0;
         transmit_irq_enable_ff <= 1'b0;
         rate_select_ff <= HDU_RATE_RST;
      end else if (wr_ctrl) begin
         receive_irq_enable_ff <= wbyte[HDU_BIT_RXIE];
         transmit_irq_enable_ff <= wbyte[HDU_BIT_TXIE];
         rate_select_ff <= wbyte[HDU_RATE_MSB:HDU_RATE_LSB];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         ninth_bit_ff <= 1'b0;
      end else if (rx_done) begin
         ninth_bit_ff <= rx_shift_ff[8];
      end else if (wr_ctrl) begin
         ninth_bit_ff <= wbyte[HDU_BIT_NINTH];
      end
   end

   // Outputs are registered; the pin falls back to the port level when idle.
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_txd <= 1'b0;
         o_transmit_output_select <= 1'b0;
         o_rx_irq <= 1'b0;
         o_tx_irq <= 1'b0;
      end else begin
         o_txd <= (state_ff == HDU_ST_TX) ? ~tx_shift_ff[0] : i_port_level;
         o_transmit_output_select <= (state_ff == HDU_ST_TX);
         o_rx_irq <= receive_full_flag_ff & receive_irq_enable_ff;
         o_tx_irq <= transmit_empty_flag_ff & transmit_irq_enable_ff;
      end
   end

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_srst);

   property p_rx_edge;
      (state_ff == HDU_ST_IDLE) && fall && !tx_start |=> (state_ff == HDU_ST_RX_START) && (phase_ff == 3'h0);
   endproperty
   a_rx_edge: assert property (p_rx_edge) else $error("falling edge did not start reception");

   property p_ninth_rx;
      rx_done |=> ninth_bit_ff == $past(rx_shift_ff[8]);
   endproperty
   a_ninth_rx: assert property (p_ninth_rx) else $error("received ninth bit not stored");

   property p_rx_buffer;
      rx_done |=> (rx_buf_ff == $past(rx_shift_ff[7:0])) && (state_ff == HDU_ST_IDLE);
   endproperty
   a_rx_buffer: assert property (p_rx_buffer) else $error("character not moved to buffer");

   property p_rx_flag;
      rx_done |=> receive_full_flag_ff ##1 (o_rx_irq == $past(receive_irq_enable_ff));
   endproperty
   a_rx_flag: assert property (p_rx_flag) else $error("receive flag or interrupt wrong");

   property p_tx_priority;
      tx_start && (state_ff != HDU_ST_IDLE) && (state_ff != HDU_ST_TX) |=> state_ff == HDU_ST_TX;
   endproperty
   a_tx_priority: assert property (p_tx_priority) else $error("transmit did not preempt reception");

   property p_tx_irq;
      !transmit_irq_enable_ff |=> !o_tx_irq;
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("transmit interrupt without enable");

   property p_tx_load;
      wr_data |=> (state_ff == HDU_ST_TX) && !transmit_empty_flag_ff && (tx_shift_ff[8:1] == $past(wbyte))
         && !tx_shift_ff[0];
   endproperty
   a_tx_load: assert property (p_tx_load) else $error("data write did not start transmission");

   property p_read_buf;
      i_avs_read && !o_avs_waitrequest && hit_data |-> o_avs_readdata == {24'h000000, $past(rx_buf_ff)};
   endproperty
   a_read_buf: assert property (p_read_buf) else $error("data read did not return buffer");

   property p_tx_done;
      tx_done |=> transmit_empty_flag_ff && (state_ff == HDU_ST_IDLE) ##1 !o_transmit_output_select;
   endproperty
   a_tx_done: assert property (p_tx_done) else $error("completion did not set empty flag");

   property p_txd_invert;
      state_ff == HDU_ST_TX |=> o_txd == !$past(tx_shift_ff[0]);
   endproperty
   a_txd_invert: assert property (p_txd_invert) else $error("serial output not inverted");

   property p_txd_idle;
      state_ff != HDU_ST_TX |=> o_txd == $past(i_port_level) && !o_transmit_output_select;
   endproperty
   a_txd_idle: assert property (p_txd_idle) else $error("idle pin does not follow port");

   property p_soft_set;
      wr_ctrl && wbyte[HDU_BIT_RXF] |=> receive_full_flag_ff;
   endproperty
   a_soft_set: assert property (p_soft_set) else $error("software set of receive flag lost");

   c_rx_char: cover property (rx_done);
   c_tx_char: cover property (tx_done);
   c_abort: cover property ((state_ff == HDU_ST_RX_DATA) && tx_start);
   c_rx_irq: cover property (o_rx_irq);

endmodule : hdu_uart

// *** rtl/hdu_pkg.sv ***
// Constants, register map and state encoding of the half-duplex nine-bit serial transceiver.
package hdu_pkg;

   // Register indices as printed; the byte address on the bus is four times the index.
   localparam logic [7:0] HDU_IDX_DATA = 8'hd6;
   localparam logic [7:0] HDU_IDX_CTRL = 8'hd7;
   localparam int HDU_ADDR_W = 10;
   localparam logic [9:0] HDU_ADDR_DATA = {HDU_IDX_DATA, 2'b00};
   localparam logic [9:0] HDU_ADDR_CTRL = {HDU_IDX_CTRL, 2'b00};

   // Field positions in the control and status register.
   localparam int HDU_BIT_RXF = 7;
   localparam int HDU_BIT_TXE = 6;
   localparam int HDU_BIT_RXIE = 5;
   localparam int HDU_BIT_TXIE = 4;
   localparam int HDU_RATE_MSB = 3;
   localparam int HDU_RATE_LSB = 1;
   localparam int HDU_BIT_NINTH = 0;

   // Values after reset.
   localparam logic [2:0] HDU_RATE_RST = 3'h0;
   localparam logic HDU_WAIT_RST = 1'b1;
   localparam logic [31:0] HDU_RDATA_RST = 32'h0000_0000;

   // Bit timing: the rate divider ticks eight times per bit.
   localparam int HDU_OVERSAMPLE = 8;
   localparam logic [2:0] HDU_SAMPLE_A = 3'h3;
   localparam logic [2:0] HDU_SAMPLE_B = 3'h4;
   localparam logic [2:0] HDU_SAMPLE_C = 3'h5;
   localparam logic [2:0] HDU_LAST_PHASE = 3'h7;
   localparam logic [3:0] HDU_LAST_RX_BIT = 4'h8;
   localparam logic [3:0] HDU_LAST_TX_BIT = 4'ha;

   // Internal clock division per bit for rate codes 0 through 6.
   localparam int HDU_DIV_0 = 6656;
   localparam int HDU_DIV_1 = 3328;
   localparam int HDU_DIV_2 = 1664;
   localparam int HDU_DIV_3 = 832;
   localparam int HDU_DIV_4 = 416;
   localparam int HDU_DIV_5 = 256;
   localparam int HDU_DIV_6 = 208;

   // Clock cycles between two oversample ticks for a rate code.
   function automatic logic [9:0] hdu_tick_limit(input logic [2:0] code);
      logic [9:0] lim;
      case (code)
         3'h0: lim = 10'(HDU_DIV_0 / HDU_OVERSAMPLE);
         3'h1: lim = 10'(HDU_DIV_1 / HDU_OVERSAMPLE);
         3'h2: lim = 10'(HDU_DIV_2 / HDU_OVERSAMPLE);
         3'h3: lim = 10'(HDU_DIV_3 / HDU_OVERSAMPLE);
         3'h4: lim = 10'(HDU_DIV_4 / HDU_OVERSAMPLE);
         3'h5: lim = 10'(HDU_DIV_5 / HDU_OVERSAMPLE);
         default: lim = 10'(HDU_DIV_6 / HDU_OVERSAMPLE);
      endcase
      return lim;
   endfunction : hdu_tick_limit

   typedef enum logic [4:0] {
      HDU_ST_IDLE = 5'h01,
      HDU_ST_RX_START = 5'h02,
      HDU_ST_RX_DATA = 5'h04,
      HDU_ST_RX_STOP = 5'h08,
      HDU_ST_TX = 5'h10
   } hdu_state_t;

endpackage : hdu_pkg

// *** rtl/hdu_rate_tick.sv ***
// Oversample tick generator dividing the internal clock for the selected rate.
`timescale 1ns/1ps
module hdu_rate_tick (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_restart,
   input wire logic [9:0] i_limit,
   output logic o_tick
);
   logic [9:0] cnt_ff;

   // The compare is against the live limit, so a new rate acts at once, even mid-bit.
   always_ff @(posedge i_mclk) begin
      if (i_srst || i_restart) begin
         cnt_ff <= 10'h000;
         o_tick <= 1'b0;
      end else if (cnt_ff >= i_limit - 10'h001) begin
         cnt_ff <= 10'h000;
         o_tick <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 10'h001;
         o_tick <= 1'b0;
      end
   end
endmodule : hdu_rate_tick

// *** verif/hdu_remote.sv ***
// Behavioural far-end serial device that sends frames on the receive line and decodes the transmit pin.
`timescale 1ns/1ps
module hdu_remote #(
   parameter int BIT_CLKS = 208
) (
   input wire logic i_mclk,
   input wire logic i_txd,
   output logic o_rxd
);
   logic [8:0] got_bits;
   logic got_stop_ok;

   initial begin
      o_rxd = 1'b1;
      got_bits = 9'h000;
      got_stop_ok = 1'b0;
   end

   // The pin is inverted, so a rising edge marks a start bit and each level is read back negated.
   always begin
      @(posedge i_txd);
      repeat (BIT_CLKS / 2) @(posedge i_mclk);
      for (int k = 0; k < 9; k++) begin
         repeat (BIT_CLKS) @(posedge i_mclk);
         got_bits[k] = ~i_txd;
      end
      repeat (BIT_CLKS) @(posedge i_mclk);
      got_stop_ok = (i_txd === 1'b0);
   end

   // The line idles high; callers keep off it while the block transmits unless a test means otherwise.
   task automatic send_frame(input logic [7:0] data, input logic ninth);
      logic [10:0] frame;
      frame = {1'b1, ninth, data, 1'b0};
      for (int k = 0; k < 11; k++) begin
         @(posedge i_mclk);
         o_rxd <= frame[k];
         repeat (BIT_CLKS - 1) @(posedge i_mclk);
      end
   endtask : send_frame
endmodule : hdu_remote

// *** verif/tb_hdu_uart.sv ***
// Self-checking testbench of the half-duplex nine-bit serial transceiver.
`timescale 1ns/1ps
module tb_hdu_uart;
   import hdu_pkg::*;
   localparam int BIT_CLKS = 208;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [9:0] av_addr = 10'h000;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [31:0] av_wdata = 32'h0000_0000;
   logic [3:0] av_be = 4'h0;
   logic [31:0] av_rdata;
   logic av_wait;
   logic rxd;
   logic port_level = 1'b0;
   logic txd;
   logic txo_sel;
   logic rx_irq;
   logic tx_irq;
   logic [7:0] rd;
   int err_count = 0;
   int n_compared = 0;

   always #20 mclk = ~mclk;

   hdu_uart DUT (.i_mclk(mclk), .i_srst(srst), .i_avs_address(av_addr), .i_avs_read(av_rd),
      .i_avs_write(av_wr), .i_avs_writedata(av_wdata), .i_avs_byteenable(av_be),
      .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .i_rxd(rxd), .i_port_level(port_level),
      .o_txd(txd), .o_transmit_output_select(txo_sel), .o_rx_irq(rx_irq), .o_tx_irq(tx_irq));

   hdu_remote #(.BIT_CLKS(BIT_CLKS)) remote (.i_mclk(mclk), .i_txd(txd), .o_rxd(rxd));

   task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic stop_test();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   // The request stays up until waitrequest is seen low; one idle edge follows so tasks can chain.
   task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
      int n;
      n = 0;
      av_addr <= a;
      av_wdata <= {24'h000000, d};
      av_be <= be;
      av_wr <= wr;
      av_rd <= ~wr;
      do begin
         @(posedge mclk);
         n++;
      end while (av_wait !== 1'b0 && n < 50);
      if (n >= 50) begin
         err_count++;
         $display("[ERR] waitrequest expected 0 seen %b", av_wait);
      end
      rd = av_rdata[7:0];
      av_wr <= 1'b0;
      av_rd <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1);
   endtask : wr

   task automatic rdchk(input logic [9:0] a, input logic [7:0] exp, input string name);
      bus(1'b0, a, 8'h00, 4'hf);
      chk(name, 9'(exp), 9'(rd));
   endtask : rdchk

   task automatic wait_tx(input int div);
      int n;
      int n0;
      n = 0;
      while (txo_sel !== 1'b1 && n < 2 * BIT_CLKS) begin
         @(posedge mclk);
         n++;
      end
      n0 = n;
      while (txo_sel !== 1'b0 && n < 16 * BIT_CLKS) begin
         @(posedge mclk);
         n++;
      end
      chk("frame end", 9'h000, 9'(txo_sel));
      chk("frame length", 9'h001, 9'(n - n0 >= 11 * div && n - n0 <= 11 * div + 2));
      repeat (4) @(posedge mclk);
   endtask : wait_tx

   initial begin
      repeat (40000) @(posedge mclk);
      err_count++;
      $display("[ERR] run expected finish seen timeout");
      stop_test();
   end

   initial begin
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      rdchk(HDU_ADDR_CTRL, 8'h00, "ctrl reset");
      rdchk(10'h000, 8'h00, "unmapped read");
      bus(1'b1, HDU_ADDR_CTRL, 8'h1c, 4'h0);
      rdchk(HDU_ADDR_CTRL, 8'h00, "ctrl no byte enable");
      wr(HDU_ADDR_CTRL, 8'h1d);
      rdchk(HDU_ADDR_CTRL, 8'h1d, "ctrl ninth as written");
      chk("tx irq idle", 9'h000, 9'(tx_irq));
      wr(HDU_ADDR_DATA, 8'ha5);
      wait_tx(HDU_DIV_6);
      chk("tx frame", {1'b1, 8'ha5}, remote.got_bits);
      chk("tx stop", 9'h001, 9'(remote.got_stop_ok));
      rdchk(HDU_ADDR_CTRL, 8'h5d, "ctrl after tx");
      chk("tx irq", 9'h001, 9'(tx_irq));
      chk("rx irq", 9'h000, 9'(rx_irq));
      wr(HDU_ADDR_CTRL, 8'h0c);
      rdchk(HDU_ADDR_CTRL, 8'h0c, "ctrl empty cleared");
      chk("tx irq cleared", 9'h000, 9'(tx_irq));
      remote.send_frame(8'h3c, 1'b1);
      repeat (20) @(posedge mclk);
      rdchk(HDU_ADDR_DATA, 8'h3c, "rx data");
      rdchk(HDU_ADDR_CTRL, 8'h8d, "ctrl after rx");
      chk("rx irq masked", 9'h000, 9'(rx_irq));
      wr(HDU_ADDR_CTRL, 8'had);
      @(posedge mclk);
      chk("rx irq enabled", 9'h001, 9'(rx_irq));
      wr(HDU_ADDR_CTRL, 8'h2d);
      rdchk(HDU_ADDR_CTRL, 8'h2d, "ctrl full cleared");
      chk("rx irq cleared", 9'h000, 9'(rx_irq));
      wr(HDU_ADDR_CTRL, 8'had);
      rdchk(HDU_ADDR_CTRL, 8'had, "ctrl full set");
      chk("rx irq soft", 9'h001, 9'(rx_irq));
      wr(HDU_ADDR_CTRL, 8'h2d);
      fork
         remote.send_frame(8'h5a, 1'b0);
         begin
            repeat (3 * BIT_CLKS) @(posedge mclk);
            wr(HDU_ADDR_DATA, 8'h81);
            wait_tx(HDU_DIV_6);
         end
      join
      chk("tx over rx", {1'b1, 8'h81}, remote.got_bits);
      rdchk(HDU_ADDR_DATA, 8'h3c, "rx abandoned");
      rdchk(HDU_ADDR_CTRL, 8'h6d, "ctrl after abandon");
      wr(HDU_ADDR_CTRL, 8'h0a);
      wr(HDU_ADDR_DATA, 8'h00);
      wait_tx(HDU_DIV_5);
      port_level <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("idle pin", 9'h001, 9'(txd));
      port_level <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("idle pin low", 9'h000, 9'(txd));
      stop_test();
   end
endmodule : tb_hdu_uart
